// File: sgp_board.sv
// Purpose: board around the pads
// Assumes: every pad line has a pull-up on the board
// Notes: a floated pad reads high
`timescale 1ns/1ps
module sgp_board (
  input wire [7:0] padOut,
  input wire [7:0] padOeLow,
  output wire [7:0] padIn,
  input wire [1:0] batPadOut,
  input wire [1:0] batPadOeLow,
  output wire [1:0] batPadIn
);
  // driven pads show their data, floated pads the pull-up
  assign padIn = padOut | padOeLow;
  assign batPadIn = batPadOut | batPadOeLow;
endmodule // sgp_board

// File: sgp_chk.sv
// Purpose: port checks for the shared pad controller
// Assumes: one clock, async active-low reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module sgp_chk #(
  parameter NPADS = 8,
  parameter NBAT = 2
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [2:0] powerState,
  input wire sysInReset,
  input wire corePowerValid,
  input wire [NPADS-1:0] szpOe,
  input wire [NPADS-1:0] hpOe,
  input wire [NPADS-1:0] lpOe,
  input wire [NPADS-1:0] szpIn,
  input wire [NPADS-1:0] hpIn,
  input wire [NPADS-1:0] lpIn,
  input wire [NPADS-1:0] padOeLow,
  input wire [NBAT-1:0] batOe,
  input wire [NBAT-1:0] batPadIn,
  input wire [NBAT-1:0] batIn,
  input wire [NBAT-1:0] batPadOeLow
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // setup phase, and setup to an unmapped word
  sequence setupS; psel && !penable; endsequence
  sequence holeS; setupS ##0 (paddr == 12'h008); endsequence
  AST_ZERO_WAIT: assert property (setupS |=> pready)
    else $error("no answer in first access cycle");
  AST_ONE_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_HOLE_ERR: assert property (holeS |=> pslverr && pready)
    else $error("unmapped word not refused");
  AST_CORE_OFF: assert property (!corePowerValid [*5] |-> &padOeLow)
    else $error("pads driven without core power");
  AST_RST_OFF: assert property (sysInReset [*4] |-> &padOeLow)
    else $error("pads driven in system reset");
  AST_DEEP_OFF: assert property ((powerState == 3'h0) [*4] |-> &padOeLow)
    else $error("pads driven in deep sleep");
  AST_SLEEP_OFF: assert property ((powerState == 3'h1) [*4] |-> &padOeLow)
    else $error("pads driven in sleep");
  AST_SLEEP_IN: assert property ((powerState == 3'h1) [*4] |-> !(|{szpIn, hpIn, lpIn}))
    else $error("input routed in sleep");
  AST_NO_OE: assert property ((szpOe == 0 && hpOe == 0 && lpOe == 0) [*4] |-> &padOeLow)
    else $error("pad driven with no owner enable");
  AST_BAT_OE: assert property ((!batOe[0]) [*4] |-> batPadOeLow[0])
    else $error("battery pad driven without enable");
  // the input path is four flops deep, so skip attempts begun at reset release
  AST_BAT_IN: assert property (($stable(batPadIn) [*4] ##0 $past(rst_n, 4)) |->
      batIn == batPadIn)
    else $error("battery input not passed");
endmodule // sgp_chk

bind sgp_pad_ctrl sgp_chk #(.NPADS(NPADS), .NBAT(NBAT)) sgp_chk_i (.*);

// File: sgp_defines.vh
// Purpose: constants for the shared pad control block
// Assumes: one clock, APB register access, 32-bit data
// Notes: offsets are byte addresses; pad words are one aligned word each
//
// Function
// R1: each pad has software owner select field
// R2: owner is secure, fast or low-power only
// R3: secure/fast pads work only in states four/three
// R4: low-power pads work except in sleep states
// R5: battery group pads work in every state
// R6: per pad choice of plain or Schmitt input
// R7: four drive levels, 2 mA up to 12 mA
// R8: per pad slow or fast slew select
// R9: open drain: data fixed, enable carries data
// R10: input mode pull-up, pull-down, keeper or plain
// R11: pads float while core power not valid
// R12: pads float in reset and deep sleep
// R13: battery pads two-way and software configured
// R14: new owner takes pad from next cycle
// R15: config fields hold until rewrite or reset
`ifndef SGP_DEFINES_VH
`define SGP_DEFINES_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SGP_STATUS_OFS 12'h000
`define SGP_ACTIVE_OFS 12'h004
`define SGP_SHARED_BASE 12'h100
`define SGP_BAT_BASE 12'h200

// ------------------------------------------------------------
// pad configuration word layout
// ------------------------------------------------------------
`define SGP_CFG_W 9
`define SGP_OWNER_LSB 0
`define SGP_SCHMITT_BIT 2
`define SGP_DRIVE_LSB 3
`define SGP_SLEW_BIT 5
`define SGP_OPEN_BIT 6
`define SGP_PULL_LSB 7
`define SGP_CFG_RESET 9'h000

// owner codes; 2'h3 is not a legal owner
`define SGP_OWN_SZP 2'h0
`define SGP_OWN_HP 2'h1
`define SGP_OWN_LP 2'h2
`define SGP_OWN_NONE 2'h3

// drive codes: 0=2 mA, 1=4 mA, 2=8 mA, 3=12 mA
`define SGP_DRIVE_2MA 2'h0
// pull codes: 0=plain, 1=pull-up, 2=pull-down, 3=keeper
`define SGP_PULL_PLAIN 2'h0

// ------------------------------------------------------------
// power state codes from the power manager
// ------------------------------------------------------------
`define SGP_PS_FOUR 3'h4
`define SGP_PS_THREE 3'h3
`define SGP_PS_SLEEP 3'h1
`define SGP_PS_DEEP 3'h0

// synchroniser depth
`define SGP_SYNC_STAGES 2

`endif

// File: sgp_pad_ctrl.v
// Purpose: shared pad ownership, gating and config over APB
// Assumes: power state and reset flag are on clk; pads are async
// Notes: zero-wait APB slave, one access cycle per transfer
//
// Implementation choices: the APB register port and the register addresses.
`include "sgp_defines.vh"
`timescale 1ns/1ps
module sgp_pad_ctrl #(
  parameter NPADS = 8,
  parameter NBAT = 2
) (
  input wire clk,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // power manager
  input wire [2:0] powerState,
  input wire sysInReset,
  input wire corePowerValid,
  // secure zone processor side
  input wire [NPADS-1:0] szpOut,
  input wire [NPADS-1:0] szpOe,
  output wire [NPADS-1:0] szpIn,
  // high performance mcu side
  input wire [NPADS-1:0] hpOut,
  input wire [NPADS-1:0] hpOe,
  output wire [NPADS-1:0] hpIn,
  // low power mcu side
  input wire [NPADS-1:0] lpOut,
  input wire [NPADS-1:0] lpOe,
  output wire [NPADS-1:0] lpIn,
  // battery always-on group logic side
  input wire [NBAT-1:0] batOut,
  input wire [NBAT-1:0] batOe,
  output reg [NBAT-1:0] batIn,
  // shared pads
  input wire [NPADS-1:0] padIn,
  output wire [NPADS-1:0] padOut,
  output wire [NPADS-1:0] padOeLow,
  output reg [NPADS-1:0] padSchmitt,
  output reg [2*NPADS-1:0] padDrive,
  output reg [NPADS-1:0] padFastSlew,
  output reg [2*NPADS-1:0] padPull,
  // battery pads
  input wire [NBAT-1:0] batPadIn,
  output wire [NBAT-1:0] batPadOut,
  output wire [NBAT-1:0] batPadOeLow,
  output reg [NBAT-1:0] batSchmitt,
  output reg [2*NBAT-1:0] batDrive,
  output reg [NBAT-1:0] batFastSlew,
  output reg [2*NBAT-1:0] batPull
);

  localparam CW = `SGP_CFG_W;

  // ----------------------------------------------------------
  // address decode helper
  // ----------------------------------------------------------
  // true when the address lands on a pad word of a region
  // slots past the last pad of a region are not hits
  // and fall through to the error answer below
  function padHit;
    input [11:0] a;
    input [11:0] base;
    input integer n;
    begin
      padHit = (a[11:8] == base[11:8]) && (a[1:0] == 2'h0) &&
               ({26'h0, a[7:2]} < n);
    end
  endfunction

  // ----------------------------------------------------------
  // synchronised inputs
  // ----------------------------------------------------------
  // pins change with no relation to clk, so two flops come first
  // power state and the reset flag share clk and need no stages
  wire powerOkSync;
  wire [NPADS-1:0] padInSync;
  wire [NBAT-1:0] batInSync;

  // core power valid comes straight from a pin
  sgp_sync #(
    .WIDTH(1)
  ) uPowerSync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(corePowerValid),
    .syncOut(powerOkSync)
  );

  // one wide synchroniser keeps shared and battery pins in step
  // all pad input levels pass two flops
  sgp_sync #(
    .WIDTH(NPADS + NBAT)
  ) uPadSync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn({batPadIn, padIn}),
    .syncOut({batInSync, padInSync})
  );

  // ----------------------------------------------------------
  // power gating
  // ----------------------------------------------------------
  // these gates act on shared pads only; battery pads ignore them
  // sleep removes every shared owner, deep sleep also forces off
  // codes other than four, three, sleep and deep let only the low-power owner work
  wire hiStates;
  wire lpStates;
  wire sharedOff;
  wire [2:0] ownAllowed;

  // secure and fast owners need state four or three
  assign hiStates = (powerState == `SGP_PS_FOUR) ||
                    (powerState == `SGP_PS_THREE); // see R3
  // low-power owner works unless asleep
  assign lpStates = (powerState != `SGP_PS_SLEEP) &&
                    (powerState != `SGP_PS_DEEP); // see R4
  assign ownAllowed = {lpStates, hiStates, hiStates};
  // float on bad core power, system reset or deep sleep
  assign sharedOff = ~powerOkSync | sysInReset |
                     (powerState == `SGP_PS_DEEP); // see R11 // see R12

  // ----------------------------------------------------------
  // apb strobes
  // ----------------------------------------------------------
  // a write lands only on the edge that sees pready high
  // slot picks the pad word inside a region
  // setup is the only cycle that loads the answer registers
  wire setup;
  wire wrCommit;
  wire sharedHit;
  wire batHit;
  wire [5:0] slot;

  assign setup = psel & ~penable;
  assign wrCommit = psel & penable & pready & pwrite;
  assign slot = paddr[7:2];
  assign sharedHit = padHit(paddr, `SGP_SHARED_BASE, NPADS);
  assign batHit = padHit(paddr, `SGP_BAT_BASE, NBAT);

  // ----------------------------------------------------------
  // shared pad slices
  // ----------------------------------------------------------
  wire [CW*NPADS-1:0] sharedCfg;
  wire [NPADS-1:0] sharedActive;

  // one slice per pad; its owner field picks the source
  // pad input goes back only to the owner that holds the pad
  genvar gi;
  generate
    for (gi = 0; gi < NPADS; gi = gi + 1) begin : gShared
      wire [2:0] route;
      sgp_pad_slice uSlice (
        .clk(clk),
        .rst_n(rst_n),
        .cfgWe(wrCommit & sharedHit & (slot == gi)), // see R1
        .cfgWdata(pwdata[CW-1:0]),
        .srcOut({lpOut[gi], hpOut[gi], szpOut[gi]}),
        .srcOe({lpOe[gi], hpOe[gi], szpOe[gi]}),
        .ownAllowed(ownAllowed),
        .forceOff(sharedOff),
        .padInSync(padInSync[gi]),
        .cfgQ(sharedCfg[gi*CW +: CW]),
        .padOutQ(padOut[gi]),
        .padOeLowQ(padOeLow[gi]),
        .activeQ(sharedActive[gi]),
        .inRouteQ(route)
      );
      assign szpIn[gi] = route[0];
      assign hpIn[gi] = route[1];
      assign lpIn[gi] = route[2];
    end
  endgenerate

  // ----------------------------------------------------------
  // battery pad slices
  // ----------------------------------------------------------
  wire [CW*NBAT-1:0] batCfg;
  wire [NBAT-1:0] batActive;
  wire [3*NBAT-1:0] batRoute;

  // always powered: only the module reset floats them
  // every legal owner code maps to the same always-on source
  // so a stored owner field changes nothing on these pads
  generate
    for (gi = 0; gi < NBAT; gi = gi + 1) begin : gBat
      sgp_pad_slice uSlice (
        .clk(clk),
        .rst_n(rst_n),
        .cfgWe(wrCommit & batHit & (slot == gi)), // see R13
        .cfgWdata(pwdata[CW-1:0]),
        .srcOut({3{batOut[gi]}}),
        .srcOe({3{batOe[gi]}}),
        .ownAllowed(3'h7), // see R5
        .forceOff(1'b0),
        .padInSync(batInSync[gi]),
        .cfgQ(batCfg[gi*CW +: CW]),
        .padOutQ(batPadOut[gi]), // see R13
        .padOeLowQ(batPadOeLow[gi]),
        .activeQ(batActive[gi]),
        .inRouteQ(batRoute[gi*3 +: 3])
      );
    end
  endgenerate

  // ----------------------------------------------------------
  // pad electrical settings
  // ----------------------------------------------------------
  integer k;

  // copy config fields to the pad cells, one flop stage
  // cells see a new field one cycle after the config word
  // battery input ORs the three routes, only the owner's route carries the pin
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      padSchmitt <= {NPADS{1'b0}};
      padDrive <= {NPADS{`SGP_DRIVE_2MA}};
      padFastSlew <= {NPADS{1'b0}};
      padPull <= {NPADS{`SGP_PULL_PLAIN}};
      batSchmitt <= {NBAT{1'b0}};
      batDrive <= {NBAT{`SGP_DRIVE_2MA}};
      batFastSlew <= {NBAT{1'b0}};
      batPull <= {NBAT{`SGP_PULL_PLAIN}};
      batIn <= {NBAT{1'b0}};
    end else begin
      for (k = 0; k < NPADS; k = k + 1) begin
        padSchmitt[k] <= sharedCfg[k*CW + `SGP_SCHMITT_BIT]; // see R6
        padDrive[k*2 +: 2] <= sharedCfg[k*CW + `SGP_DRIVE_LSB +: 2]; // see R7
        padFastSlew[k] <= sharedCfg[k*CW + `SGP_SLEW_BIT]; // see R8
        padPull[k*2 +: 2] <= sharedCfg[k*CW + `SGP_PULL_LSB +: 2]; // see R10
      end
      for (k = 0; k < NBAT; k = k + 1) begin
        batSchmitt[k] <= batCfg[k*CW + `SGP_SCHMITT_BIT]; // see R13
        batDrive[k*2 +: 2] <= batCfg[k*CW + `SGP_DRIVE_LSB +: 2];
        batFastSlew[k] <= batCfg[k*CW + `SGP_SLEW_BIT];
        batPull[k*2 +: 2] <= batCfg[k*CW + `SGP_PULL_LSB +: 2];
        batIn[k] <= |batRoute[k*3 +: 3];
      end
    end
  end

  // ----------------------------------------------------------
  // read data select
  // ----------------------------------------------------------
  reg [31:0] rdata_d;
  reg err_d;
  wire [31:0] statusWord;
  wire [31:0] activeWord;

  // status bits: core power, reset flag, state, gates, forced off
  assign statusWord = {24'h0, sharedOff, lpStates, hiStates,
                       powerState, sysInReset, powerOkSync};
  assign activeWord = {{(32-NPADS-NBAT){1'b0}}, batActive, sharedActive};

  // unmapped or misaligned addresses answer with an error
  // status and active words are read-only, writes are refused
  // config bits above the word width read back as zero
  always @* begin
    rdata_d = 32'h0;
    err_d = 1'b0;
    if (paddr == `SGP_STATUS_OFS) begin
      rdata_d = statusWord;
      err_d = pwrite;
    end else if (paddr == `SGP_ACTIVE_OFS) begin
      rdata_d = activeWord;
      err_d = pwrite;
    end else if (sharedHit) begin
      rdata_d = {{(32-CW){1'b0}}, sharedCfg[slot*CW +: CW]};
    end else if (batHit) begin
      rdata_d = {{(32-CW){1'b0}}, batCfg[slot*CW +: CW]};
    end else begin
      err_d = 1'b1;
    end
  end

  // ----------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------
  // answer ready in the first access cycle, held for one cycle
  // read data is captured at setup and holds until the next setup
  // pslverr falls with pready so it never outlives the answer
  // back to back transfers work since a setup can follow any access
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rdata_d;
        pslverr <= err_d;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // sgp_pad_ctrl

// File: sgp_pad_slice.v
// Purpose: config word, owner mux and output gating for one pad
// Assumes: source data and enables are on clk
// Notes: all outputs are registered
`include "sgp_defines.vh"
`timescale 1ns/1ps
module sgp_pad_slice (
  input wire clk,
  input wire rst_n,
  input wire cfgWe,
  input wire [`SGP_CFG_W-1:0] cfgWdata,
  input wire [2:0] srcOut,
  input wire [2:0] srcOe,
  input wire [2:0] ownAllowed,
  input wire forceOff,
  input wire padInSync,
  output reg [`SGP_CFG_W-1:0] cfgQ,
  output reg padOutQ,
  output reg padOeLowQ,
  output reg activeQ,
  output reg [2:0] inRouteQ
);

  wire [1:0] owner;
  wire openDrain;
  reg selOut;
  reg selOe;
  reg allowed;
  wire active;

  assign owner = cfgQ[`SGP_OWNER_LSB +: 2];
  assign openDrain = cfgQ[`SGP_OPEN_BIT];

  // ----------------------------------------------------------
  // configuration word
  // ----------------------------------------------------------
  // fields hold until rewritten or reset; owner 3 is refused
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgQ <= `SGP_CFG_RESET; // see R15
    end else if (cfgWe) begin
      cfgQ[`SGP_CFG_W-1:2] <= cfgWdata[`SGP_CFG_W-1:2]; // see R6 // see R7
      if (cfgWdata[1:0] != `SGP_OWN_NONE) begin
        cfgQ[1:0] <= cfgWdata[1:0]; // see R1 // see R2
      end
    end
  end

  // ----------------------------------------------------------
  // owner mux
  // ----------------------------------------------------------
  // picks the owner's data, enable and power permission
  always @* begin
    selOut = 1'b0;
    selOe = 1'b0;
    allowed = 1'b0;
    case (owner)
      `SGP_OWN_SZP: begin
        selOut = srcOut[0];
        selOe = srcOe[0];
        allowed = ownAllowed[0];
      end
      `SGP_OWN_HP: begin
        selOut = srcOut[1];
        selOe = srcOe[1];
        allowed = ownAllowed[1];
      end
      `SGP_OWN_LP: begin
        selOut = srcOut[2];
        selOe = srcOe[2];
        allowed = ownAllowed[2];
      end
      default: begin
        selOut = 1'b0;
        selOe = 1'b0;
        allowed = 1'b0;
      end
    endcase
  end

  assign active = allowed & ~forceOff; // see R11 // see R12

  // ----------------------------------------------------------
  // registered pad drive and input routing
  // ----------------------------------------------------------
  // open drain drives low on data 0 and floats on data 1
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      padOutQ <= 1'b0;
      padOeLowQ <= 1'b1;
      activeQ <= 1'b0;
      inRouteQ <= 3'h0;
    end else begin
      activeQ <= active;
      if (!active) begin
        padOutQ <= 1'b0;
        padOeLowQ <= 1'b1; // see R11 // see R12
      end else if (openDrain) begin
        padOutQ <= 1'b0; // see R9
        padOeLowQ <= ~(selOe & ~selOut); // see R9
      end else begin
        padOutQ <= selOut; // see R14
        padOeLowQ <= ~selOe; // see R14
      end
      inRouteQ[0] <= active & (owner == `SGP_OWN_SZP) & padInSync;
      inRouteQ[1] <= active & (owner == `SGP_OWN_HP) & padInSync;
      inRouteQ[2] <= active & (owner == `SGP_OWN_LP) & padInSync;
    end
  end

endmodule // sgp_pad_slice

// File: sgp_sync.v
// Purpose: two-stage synchroniser for pin-level inputs
// Assumes: inputs are levels, not pulses
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module sgp_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] meta_q;

  // two flops in series, cleared by reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule // sgp_sync

// File: tb.sv
// Purpose: self-checking bench for the shared pad controller
// Assumes: default pad counts, zero-wait bus
// Notes: a bench model predicts every pad and register
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, sysInReset, corePowerValid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic [2:0] powerState;
  logic [7:0] szpOut, szpOe, hpOut, hpOe, lpOut, lpOe, szpIn, hpIn, lpIn, padIn, padOut;
  logic [7:0] padOeLow, padSchmitt, padFastSlew;
  logic [15:0] padDrive, padPull;
  logic [1:0] batOut, batOe, batIn, batPadIn, batPadOut, batPadOeLow, batSchmitt, batFastSlew;
  logic [3:0] batDrive, batPull;
  logic [9:0] eOut, eOel, eSz, eHp, eLp, eRt, eSch, eSlw, eAct, sO, hO, lO, sE, hE, lE;
  logic [19:0] eDrv, ePul;
  logic [8:0] cfg [10];
  logic [1:0] own;
  logic e, act, d, oe, frc;
  integer seed, nMismatch, totalChecks, k, i;
  sgp_pad_ctrl sgp_pad_ctrl_i (.*);
  sgp_board sgp_board_i (.*);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task summarize;
    if (nMismatch == 0 && totalChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus transfer, then one idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    integer n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1 && n < 20);
    if (n >= 20) begin
      nMismatch++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, sysInReset, corePowerValid} = 0;
    {szpOut, szpOe, hpOut, hpOe, lpOut, lpOe, batOut, batOe, powerState} = 0;
    seed = 44238;
    nMismatch = 0;
    totalChecks = 0;
    for (i = 0; i < 10; i++) cfg[i] = 0;
    repeat (16) @(posedge clk);
    chk("rstFloat", {batPadOeLow, padOeLow}, 10'h3ff);
    rst_n <= 1;
    @(posedge clk);
    apb(0, 12'h100, 0);
    chk("cfgReset", r, 0);
    for (k = 0; k < 24; k++) begin
      powerState <= k % 8;
      sysInReset <= k >= 8 && k < 16;
      corePowerValid <= k < 16;
      {szpOut, hpOut, lpOut, batOut} <= {$random(seed), $random(seed)};
      {szpOe, hpOe, lpOe, batOe} <= (k % 3) ? {$random(seed), $random(seed)} : 0;
      frc = k >= 8 || k % 8 == 0;
      // random config for every pad, owner code 3 keeps the old owner
      for (i = 0; i < 10; i++) begin
        v = $random(seed);
        apb(1, (i < 8) ? 12'h100 + 4 * i : 12'h200 + 4 * (i - 8), v);
        if (v[1:0] == 2'h3) v[1:0] = cfg[i][1:0];
        cfg[i] = v[8:0];
        apb(0, (i < 8) ? 12'h100 + 4 * i : 12'h200 + 4 * (i - 8), 0);
        chk("cfg", r, cfg[i]);
      end
      repeat (6) @(posedge clk);
      {sO, hO, lO} = {batOut, szpOut, batOut, hpOut, batOut, lpOut};
      {sE, hE, lE} = {batOe, szpOe, batOe, hpOe, batOe, lpOe};
      for (i = 0; i < 10; i++) begin
        own = cfg[i][1:0];
        act = i > 7 || (!frc && (own == 2 ? k % 8 > 1 : (k % 8 == 3 || k % 8 == 4)));
        d = own == 0 ? sO[i] : own == 1 ? hO[i] : lO[i];
        oe = own == 0 ? sE[i] : own == 1 ? hE[i] : lE[i];
        eOel[i] = !(act && oe && (!cfg[i][6] || !d));
        eOut[i] = act && !cfg[i][6] && d;
        eRt[i] = eOel[i] | eOut[i];
        eSz[i] = act && own == 0 && eRt[i];
        eHp[i] = act && own == 1 && eRt[i];
        eLp[i] = act && own == 2 && eRt[i];
        ePul[2*i+:2] = cfg[i][8:7];
        eSlw[i] = cfg[i][5];
        eDrv[2*i+:2] = cfg[i][4:3];
        eSch[i] = cfg[i][2];
        eAct[i] = act;
      end
      chk("padOut", {batPadOut, padOut}, eOut);
      chk("oeLow", {batPadOeLow, padOeLow}, eOel);
      chk("szpIn", szpIn, eSz[7:0]);
      chk("hpIn", hpIn, eHp[7:0]);
      chk("lpIn", lpIn, eLp[7:0]);
      chk("batIn", batIn, eRt[9:8]);
      chk("schmitt", {batSchmitt, padSchmitt}, eSch);
      chk("drive", {batDrive, padDrive}, eDrv);
      chk("slew", {batFastSlew, padFastSlew}, eSlw);
      chk("pull", {batPull, padPull}, ePul);
      apb(0, 12'h000, 0);
      chk("status", r, {frc, k % 8 > 1, k % 8 == 3 || k % 8 == 4, 3'(k % 8), k >= 8 && k < 16, k < 16});
      apb(0, 12'h004, 0);
      chk("active", r, eAct);
      apb(0, 12'h008, 0);
      chk("holeErr", e, 1);
      apb(1, 12'h004, 32'hffff_ffff);
      chk("roErr", e, 1);
    end
    // mid-run reset must float the pads and clear every config word
    rst_n <= 0;
    repeat (2) @(posedge clk);
    chk("rstFloat2", {batPadOeLow, padOeLow}, 10'h3ff);
    rst_n <= 1;
    @(posedge clk);
    for (i = 0; i < 10; i++) begin
      apb(0, (i < 8) ? 12'h100 + 4 * i : 12'h200 + 4 * (i - 8), 0);
      chk("cfgReset2", r, 0);
    end
    summarize();
  end
endmodule // tb
